/* verilog/ocfr_cfg.svh */
`ifndef OCFR_CFG_SVH
`define OCFR_CFG_SVH
// command codes
`define OCFR_CMD_CLEAR_FAULTS   8'h03
`define OCFR_CMD_OPERATION      8'h01
`define OCFR_CMD_OC_LIMIT       8'h46
`define OCFR_CMD_OC_RESPONSE    8'h47
`define OCFR_CMD_LV_FLOOR       8'h48
`define OCFR_CMD_STATUS         8'h7B
`define OCFR_CMD_TIME_UNIT      8'hD2
// response field layout
`define OCFR_RESP_MODE_HI       7
`define OCFR_RESP_MODE_LO       6
`define OCFR_RESP_RETRY_HI      5
`define OCFR_RESP_RETRY_LO      3
`define OCFR_RESP_DELAY_HI      2
`define OCFR_RESP_DELAY_LO      0
`define OCFR_RETRY_NONE         3'h0
`define OCFR_RETRY_FOREVER      3'h7
`define OCFR_OPERATION_ON_BIT   7
// reset values
`define OCFR_RST_OC_LIMIT       16'hFFFF
`define OCFR_RST_OC_RESPONSE    8'h00
`define OCFR_RST_LV_FLOOR       16'h0000
`define OCFR_RST_OPERATION      8'h80
// timing
`define OCFR_CLK_MHZ            250
`define OCFR_TIME_UNIT_NS       1000
`define OCFR_TIME_UNIT_CYC      (`OCFR_TIME_UNIT_NS * `OCFR_CLK_MHZ / 1000)
`define OCFR_RST_TIME_UNIT      16'(`OCFR_TIME_UNIT_CYC)
`endif

/* verilog/ocfr_pkg.sv */
`default_nettype none
package ocfr_pkg;
	typedef enum logic [1:0] {
		OCFR_MODE_CC      = 2'b00,
		OCFR_MODE_COND_CC = 2'b01,
		OCFR_MODE_DELAY   = 2'b10,
		OCFR_MODE_RESUME  = 2'b11
	} ocfr_mode_e;

	typedef enum logic [2:0] {
		OCFR_ST_OFF   = 3'b000,
		OCFR_ST_RUN   = 3'b001,
		OCFR_ST_LIMIT = 3'b010,
		OCFR_ST_HOLD  = 3'b011,
		OCFR_ST_WAIT  = 3'b100,
		OCFR_ST_LATCH = 3'b101
	} ocfr_state_e;
endpackage
`default_nettype wire

/* verilog/ocfr_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ocfr_timer_if;
	logic        start;
	logic        clear;
	logic [2:0]  code;
	logic [15:0] unit_len;
	logic        expired;
	logic        running;
	modport ctrl  (output start, output clear, output code, output unit_len,
		input expired, input running);
	modport timer (input start, input clear, input code, input unit_len,
		output expired, output running);
endinterface // ocfr_timer_if
`default_nettype wire

/* verilog/ocfr_delay_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ocfr_delay_timer
	import ocfr_pkg::*;
(
	// clock and reset
	input wire logic     mclk,
	input wire logic     sys_rst,
	// control
	ocfr_timer_if.timer  tif
);
	logic [15:0] unit_cnt_q;
	logic [7:0]  tick_cnt_q;
	logic [7:0]  target;
	logic [15:0] unit_last;
	logic        run_q;
	logic        expired_q;

	assign target    = 8'h01 << tif.code;
	assign unit_last = (tif.unit_len == 16'h0000) ? 16'h0000 : tif.unit_len - 16'h0001;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk) begin
		if (sys_rst || tif.clear) begin
			run_q      <= 1'b0;
			unit_cnt_q <= 16'h0000;
			tick_cnt_q <= 8'h00;
			expired_q  <= 1'b0;
		end else if (tif.start) begin
			run_q      <= 1'b1;
			unit_cnt_q <= 16'h0000;
			tick_cnt_q <= 8'h00;
			expired_q  <= 1'b0;
		end else begin
			expired_q <= 1'b0;
			if (run_q) begin
				if (unit_cnt_q >= unit_last) begin
					unit_cnt_q <= 16'h0000;
					if (tick_cnt_q == target - 8'h01) begin
						run_q     <= 1'b0;
						expired_q <= 1'b1;
					end else begin
						tick_cnt_q <= tick_cnt_q + 8'h01;
					end
				end else begin
					unit_cnt_q <= unit_cnt_q + 16'h0001;
				end
			end
		end
	end

	assign tif.expired = expired_q;
	assign tif.running = run_q;
endmodule // ocfr_delay_timer
`default_nettype wire

/* verilog/ocfr_top.sv */
// Behaviour
// - 16-bit overcurrent limit at code 0x46
// - response setting 0x47: mode, retries, delay
// - overcurrent while not off sets flag, alerts host
// - mode 00 limits current forever
// - mode 01 limits; low voltage shuts down
// - mode 10 limits for delay, then retry
// - mode 11 disabled while fault persists
// - retry 000: stay off until cleared
// - retry 1-6: that many attempts, then latch off
// - retry 111 forever until off or fault
// - delay field means two^n time units
// - delay times operation or restart spacing
// - time unit length from code 0xD2
// - voltage floor held at code 0x48
`timescale 1ns/1ps
`default_nettype none
`include "ocfr_cfg.svh"
module ocfr_top
	import ocfr_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// command port
	input  wire logic        cmd_wr,
	input  wire logic        cmd_rd,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [15:0] cmd_wdata,
	output logic      [15:0] cmd_rdata,
	output logic             cmd_rvalid,
	// sensing and pins
	input  wire logic [15:0] iout_meas,
	input  wire logic [15:0] vout_meas,
	input  wire logic        ctrl_pin,
	input  wire logic        other_fault,
	// power stage and host
	output logic             output_enable,
	output logic             current_limit_active,
	output logic      [15:0] current_limit_value,
	output logic             oc_fault_flag,
	output logic             host_alert
);
	logic [15:0]  oc_limit_q;
	logic [7:0]   oc_resp_q;
	logic [15:0]  lv_floor_q;
	logic [15:0]  time_unit_q;
	logic [7:0]   operation_q;
	logic         ctrl_s1_q;
	logic         ctrl_s2_q;
	logic         oflt_s1_q;
	logic         oflt_s2_q;
	ocfr_state_e  state_q;
	ocfr_state_e  state_d;
	logic [2:0]   retry_q;
	logic [2:0]   retry_d;
	logic         flag_q;
	logic [15:0]  rdata_q;
	logic         rvalid_q;
	logic         oc_det;
	logic         v_low;
	logic         on_cmd;
	logic         clr_cmd;
	ocfr_mode_e   mode;
	logic [2:0]   retries;
	ocfr_timer_if tif ();

	ocfr_delay_timer u_timer (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.tif     (tif)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctrl_s1_q <= 1'b0;
			ctrl_s2_q <= 1'b0;
			oflt_s1_q <= 1'b0;
			oflt_s2_q <= 1'b0;
		end else begin
			ctrl_s1_q <= ctrl_pin;
			ctrl_s2_q <= ctrl_s1_q;
			oflt_s1_q <= other_fault;
			oflt_s2_q <= oflt_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			oc_limit_q  <= `OCFR_RST_OC_LIMIT;
			oc_resp_q   <= `OCFR_RST_OC_RESPONSE;
			lv_floor_q  <= `OCFR_RST_LV_FLOOR;
			time_unit_q <= `OCFR_RST_TIME_UNIT;
			operation_q <= `OCFR_RST_OPERATION;
		end else if (cmd_wr) begin
			case (cmd_code)
				`OCFR_CMD_OC_LIMIT:    oc_limit_q  <= cmd_wdata;
				`OCFR_CMD_OC_RESPONSE: oc_resp_q   <= cmd_wdata[7:0];
				`OCFR_CMD_LV_FLOOR:    lv_floor_q  <= cmd_wdata;
				`OCFR_CMD_TIME_UNIT:   time_unit_q <= cmd_wdata;
				`OCFR_CMD_OPERATION:   operation_q <= cmd_wdata[7:0];
				default:               ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata_q  <= 16'h0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= cmd_rd;
			if (cmd_rd) begin
				case (cmd_code)
					`OCFR_CMD_OC_LIMIT:    rdata_q <= oc_limit_q;
					`OCFR_CMD_OC_RESPONSE: rdata_q <= {8'h00, oc_resp_q};
					`OCFR_CMD_LV_FLOOR:    rdata_q <= lv_floor_q;
					`OCFR_CMD_TIME_UNIT:   rdata_q <= time_unit_q;
					`OCFR_CMD_OPERATION:   rdata_q <= {8'h00, operation_q};
					`OCFR_CMD_STATUS:      rdata_q <= {9'h000, tif.running, retry_q,
						state_q == OCFR_ST_LATCH, output_enable, flag_q};
					default:               rdata_q <= 16'h0000;
				endcase
			end
		end
	end

	assign mode    = ocfr_mode_e'(oc_resp_q[`OCFR_RESP_MODE_HI:`OCFR_RESP_MODE_LO]);
	assign retries = oc_resp_q[`OCFR_RESP_RETRY_HI:`OCFR_RESP_RETRY_LO];
	assign oc_det  = iout_meas >= oc_limit_q;
	assign v_low   = vout_meas < lv_floor_q;
	assign on_cmd  = ctrl_s2_q && operation_q[`OCFR_OPERATION_ON_BIT];
	assign clr_cmd = cmd_wr && (cmd_code == `OCFR_CMD_CLEAR_FAULTS);

	assign tif.code     = oc_resp_q[`OCFR_RESP_DELAY_HI:`OCFR_RESP_DELAY_LO];
	assign tif.unit_len = time_unit_q;

	////////////////////////////////////////////////////////////////////////////////
	// fault flag, set wins over clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flag_q <= 1'b0;
		end else if (oc_det && state_q != OCFR_ST_OFF) begin
			flag_q <= 1'b1;
		end else if (clr_cmd) begin
			flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// response sequencer
	always_comb begin
		state_d   = state_q;
		retry_d   = retry_q;
		tif.start = 1'b0;
		tif.clear = 1'b0;
		if (!on_cmd || clr_cmd) begin
			state_d   = on_cmd ? OCFR_ST_RUN : OCFR_ST_OFF;
			retry_d   = 3'h0;
			tif.clear = 1'b1;
		end else if (oflt_s2_q) begin
			state_d   = OCFR_ST_LATCH;
			tif.clear = 1'b1;
		end else begin
			case (state_q)
				OCFR_ST_OFF: state_d = OCFR_ST_RUN;
				OCFR_ST_RUN: begin
					if (oc_det) begin
						case (mode)
							OCFR_MODE_CC: state_d = OCFR_ST_LIMIT;
							OCFR_MODE_COND_CC: begin
								state_d = v_low ? OCFR_ST_WAIT : OCFR_ST_LIMIT;
								tif.start = v_low;
							end
							OCFR_MODE_DELAY: begin
								state_d   = OCFR_ST_LIMIT;
								tif.start = 1'b1;
							end
							default: state_d = OCFR_ST_HOLD;
						endcase
					end
				end
				OCFR_ST_LIMIT: begin
					if (!oc_det) begin
						state_d   = OCFR_ST_RUN;
						tif.clear = 1'b1;
					end else if (mode == OCFR_MODE_RESUME) begin
						state_d = OCFR_ST_HOLD;
					end else if ((mode == OCFR_MODE_COND_CC && v_low) ||
						(mode == OCFR_MODE_DELAY && tif.expired)) begin
						state_d   = OCFR_ST_WAIT;
						tif.start = 1'b1;
					end
				end
				OCFR_ST_HOLD: begin
					if (!oc_det) begin
						state_d = OCFR_ST_RUN;
					end
				end
				OCFR_ST_WAIT: begin
					if (retries == `OCFR_RETRY_NONE) begin
						state_d   = OCFR_ST_LATCH;
						tif.clear = 1'b1;
					end else if (tif.expired) begin
						if (retries == `OCFR_RETRY_FOREVER) begin
							state_d = OCFR_ST_RUN;
						end else if (retry_q < retries) begin
							state_d = OCFR_ST_RUN;
							retry_d = retry_q + 3'h1;
						end else begin
							state_d = OCFR_ST_LATCH;
						end
					end
				end
				OCFR_ST_LATCH: state_d = OCFR_ST_LATCH;
				default: state_d = OCFR_ST_OFF;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= OCFR_ST_OFF;
			retry_q <= 3'h0;
		end else begin
			state_q <= state_d;
			retry_q <= retry_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign output_enable        = (state_q == OCFR_ST_RUN) || (state_q == OCFR_ST_LIMIT);
	assign current_limit_active = (state_q == OCFR_ST_LIMIT);
	assign current_limit_value  = oc_limit_q;
	assign oc_fault_flag        = flag_q;
	assign host_alert           = flag_q;
	assign cmd_rdata            = rdata_q;
	assign cmd_rvalid           = rvalid_q;
endmodule // ocfr_top
`default_nettype wire

/* sim/ocfr_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module ocfr_top_props (
	// clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// command port
	input wire logic        cmd_wr,
	input wire logic        cmd_rd,
	input wire logic [7:0]  cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic        cmd_rvalid,
	// sensing and outputs
	input wire logic [15:0] iout_meas,
	input wire logic        ctrl_pin,
	input wire logic        other_fault,
	input wire logic        output_enable,
	input wire logic        current_limit_active,
	input wire logic [15:0] current_limit_value,
	input wire logic        oc_fault_flag,
	input wire logic        host_alert
);
	logic [1:0] mode_q;
	logic       oc;
	assign oc = iout_meas >= current_limit_value;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// response mode as last written
	always_ff @(posedge mclk) begin
		if (sys_rst)
			mode_q <= 2'b00;
		else if (cmd_wr && cmd_code == 8'h47)
			mode_q <= cmd_wdata[7:6];
	end
	////////////////////////////////////////////////////////////////
	AST_RVALID: assert property (1'b1 |=> cmd_rvalid == $past(cmd_rd))
		else $error("read answer timing");
	AST_LIMIT_WR: assert property (cmd_wr && cmd_code == 8'h46
		|=> current_limit_value == $past(cmd_wdata)) else $error("limit not written");
	AST_RST_VAL: assert property ($fell(sys_rst)
		|-> !output_enable && !oc_fault_flag && current_limit_value == 16'hffff)
		else $error("reset values");
	AST_ALERT: assert property (host_alert == oc_fault_flag)
		else $error("alert differs from flag");
	AST_STICKY: assert property (oc_fault_flag && !(cmd_wr && cmd_code == 8'h03)
		|=> oc_fault_flag) else $error("flag dropped");
	AST_FLAG_SET: assert property (output_enable && oc |-> ##[1:2] oc_fault_flag)
		else $error("flag not set");
	AST_LIMIT_ON: assert property (current_limit_active |-> output_enable)
		else $error("limiting with output off");
	AST_RESUME: assert property (mode_q == 2'b11 && output_enable && oc
		|-> ##[1:2] !output_enable) else $error("output kept on");
	AST_DLY_START: assert property (mode_q == 2'b10 && output_enable
		&& !current_limit_active && oc |=> current_limit_active) else $error("no limiting");
	AST_ALERT_CAUSE: assert property ($rose(host_alert) |-> $past(oc))
		else $error("alert without overcurrent");
	AST_LIMIT_END: assert property (current_limit_active && !oc |=> !current_limit_active)
		else $error("limiting after current fell");
	AST_CTRL_OFF: assert property ((!ctrl_pin) [*3] |=> !output_enable)
		else $error("output on with control low");
	AST_OTHER_OFF: assert property ((other_fault && !cmd_wr) [*3] |=> !output_enable)
		else $error("output on during other fault");
endmodule // ocfr_top_props
bind ocfr_top ocfr_top_props u_props (.*);
`default_nettype wire

/* sim/ocfr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ocfr_host_model (
	// clock
	input wire logic        mclk,
	// command port
	output logic            cmd_wr,
	output logic            cmd_rd,
	output logic [7:0]      cmd_code,
	output logic [15:0]     cmd_wdata,
	input wire logic [15:0] cmd_rdata,
	input wire logic        cmd_rvalid
);
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// released lines never keep the old value
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge mclk);
		#1;
		cmd_wr = 1'b1;
		cmd_code = c;
		cmd_wdata = d;
		@(posedge mclk);
		#1;
		cmd_wr = 1'b0;
		cmd_code = ~c;
		cmd_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(posedge mclk);
		#1;
		cmd_rd = 1'b1;
		cmd_code = c;
		@(posedge mclk);
		#1;
		cmd_rd = 1'b0;
		cmd_code = ~c;
		d = cmd_rvalid ? cmd_rdata : ~cmd_rdata;
	endtask
endmodule // ocfr_host_model
`default_nettype wire

/* sim/test_overcurrent_fault_response.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ocfr_cfg.svh"
module test_overcurrent_fault_response;
	logic        mclk, sys_rst, ctrl_pin, other_fault, cmd_wr, cmd_rd, cmd_rvalid, prev_oe;
	logic        output_enable, current_limit_active, oc_fault_flag, host_alert;
	logic [7:0]  cmd_code;
	logic [15:0] cmd_wdata, cmd_rdata, iout_meas, vout_meas, current_limit_value, rd_v, w, e;
	logic [31:0] lfsr;
	int          n_errors, cmp_count, falls, act, cyc, a0;
	logic [7:0]  codes [5] = '{8'h46, 8'h47, 8'h48, 8'hd2, 8'h20};
	logic [15:0] rstv [5] = '{`OCFR_RST_OC_LIMIT, 16'(`OCFR_RST_OC_RESPONSE),
		`OCFR_RST_LV_FLOOR, `OCFR_RST_TIME_UNIT, 16'h0000};
	ocfr_top DUT (.mclk, .sys_rst, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata,
		.cmd_rvalid, .iout_meas, .vout_meas, .ctrl_pin, .other_fault, .output_enable,
		.current_limit_active, .current_limit_value, .oc_fault_flag, .host_alert);
	ocfr_host_model u_host (.mclk, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_rdata,
		.cmd_rvalid);
	////////////////////////////////////////////////////////////////
	function automatic logic [15:0] nxt();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[15:0];
	endfunction
	function automatic logic [15:0] hi();
		return 16'd100 + nxt() % 16'd900;
	endfunction
	// extra limiting cycles over a one-unit delay, unit of 3
	function automatic int dly(input logic [2:0] d);
		return ((1 << d) - 1) * 3;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic arm(input logic [7:0] r);
		iout_meas = 16'h0000;
		u_host.wr(8'h03, 16'h0000);
		u_host.wr(8'h47, {8'h00, r});
		falls = 0;
		act = 0;
	endtask
	task automatic tally_and_finish;
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always #2 mclk = ~mclk;
	// output drops, limiting cycles, hang guard
	always @(posedge mclk) begin
		prev_oe <= output_enable;
		if (prev_oe === 1'b1 && output_enable === 1'b0)
			falls++;
		if (current_limit_active === 1'b1)
			act++;
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish;
		end
	end
	initial begin
		mclk = 1'b0;
		sys_rst = 1'b1;
		ctrl_pin = 1'b1;
		other_fault = 1'b0;
		prev_oe = 1'b0;
		iout_meas = 16'h0000;
		vout_meas = 16'hffff;
		lfsr = 32'h8a81;
		repeat (5) @(posedge mclk);
		#1;
		sys_rst = 1'b0;
		for (int i = 0; i < 5; i++) begin
			u_host.rd(codes[i], rd_v);
			chk(rd_v, rstv[i]);
		end
		for (int i = 0; i < 8; i++) begin
			w = nxt() | 16'h0001;
			e = (i % 4 == 1) ? {8'h00, w[7:0]} : w;
			u_host.wr(codes[i % 4], w);
			u_host.rd(codes[i % 4], rd_v);
			chk(rd_v, e);
		end
		u_host.wr(8'h46, 16'd100);
		chk(current_limit_value, 16'd100);
		u_host.wr(8'hd2, 16'd3);
		u_host.wr(8'h48, 16'd50);
		for (int r = 0; r < 7; r++) begin
			arm({2'b10, 3'(r), 3'(nxt() % 3)});
			iout_meas = hi();
			wt(700);
			chk(falls, r + 1);
			chk({output_enable, host_alert, oc_fault_flag}, 3'b011);
			u_host.rd(8'h7b, rd_v);
			chk(rd_v, {10'h000, 3'(r), 3'b101});
			arm(8'h00);
			wt(5);
			chk(output_enable, 1'b1);
			u_host.rd(8'h7b, rd_v);
			chk(rd_v, 16'h0002);
		end
		arm(8'hb8);
		iout_meas = hi();
		wt(700);
		chk(falls > 30, 1'b1);
		iout_meas = 16'h0000;
		ctrl_pin = 1'b0;
		wt(10);
		chk(output_enable, 1'b0);
		ctrl_pin = 1'b1;
		wt(10);
		chk(output_enable, 1'b1);
		arm(8'hb8);
		iout_meas = hi();
		wt(50);
		u_host.wr(8'h01, 16'h0000);
		wt(20);
		a0 = falls;
		wt(100);
		chk({output_enable, falls == a0}, 2'b01);
		iout_meas = 16'h0000;
		u_host.wr(8'h01, 16'h0080);
		wt(5);
		chk(output_enable, 1'b1);
		other_fault = 1'b1;
		wt(10);
		chk(output_enable, 1'b0);
		other_fault = 1'b0;
		wt(10);
		chk(output_enable, 1'b0);
		arm(8'h00);
		wt(5);
		chk(output_enable, 1'b1);
		for (int k = 0; k < 2; k++) begin
			arm(8'h80);
			iout_meas = hi();
			wt(100);
			a0 = act;
			w[2:0] = k ? 3'd7 : 3'(nxt() % 7);
			arm({5'b10000, w[2:0]});
			iout_meas = hi();
			wt(500);
			chk(act - a0, dly(w[2:0]));
		end
		arm(8'h00);
		iout_meas = hi();
		vout_meas = 16'h0000;
		wt(300);
		chk({output_enable, current_limit_active, falls[3:0]}, 6'b110000);
		arm(8'h40);
		vout_meas = 16'd200;
		iout_meas = hi();
		wt(100);
		chk(output_enable, 1'b1);
		vout_meas = 16'd10;
		wt(100);
		chk({output_enable, falls[3:0]}, 5'b00001);
		arm(8'hc0);
		iout_meas = hi();
		wt(20);
		chk(output_enable, 1'b0);
		iout_meas = 16'h0000;
		wt(20);
		chk(output_enable, 1'b1);
		arm(8'h87);
		iout_meas = hi();
		wt(50);
		u_host.rd(8'h7b, rd_v);
		chk(rd_v, 16'h0043);
		iout_meas = 16'h0000;
		wt(500);
		chk({output_enable, falls[3:0]}, 5'b10000);
		u_host.rd(8'h7b, rd_v);
		chk(rd_v, 16'h0003);
		tally_and_finish;
	end
endmodule // test_overcurrent_fault_response
`default_nettype wire
